// ===== pct_defs.svh
// Timing counts, sizes and fixed figures of the core timing block
`ifndef PCT_DEFS_SVH
`define PCT_DEFS_SVH

// Extra cycles of a conditional branch when it is taken
`define PCT_BRANCH_PENALTY 4'h2
// Longest instruction in cycles
`define PCT_MAX_CYCLES 4'h8
// Shortest instruction in cycles
`define PCT_MIN_CYCLES 4'h1
// Internal data RAM size in bytes
`define PCT_IRAM_BYTES 256
// Special function space size in bytes and its first direct address
`define PCT_SFR_BYTES 128
`define PCT_SFR_BASE 8'h80
// Default on-chip expansion RAM size in bytes
`define PCT_EXPANSION_DATA_RAM_BYTES 4096
// Field positions of the status-word write mask
`define PCT_PSW_CY 2
`define PCT_PSW_AC 1
`define PCT_PSW_OV 0

`endif

// ===== pct_pkg.sv
// Types shared by the core timing block
package pct_pkg;

   // Sequencer states
   typedef enum logic [1:0] {
      pct_st_idle,
      pct_st_exec,
      pct_st_halt
   } pct_state_type;

   // Target space of an external-data move or code read
   typedef enum logic [1:0] {
      pct_sp_none,
      pct_sp_expansion_data_ram,
      pct_sp_offchip,
      pct_sp_flash
   } pct_space_type;

   // Decoded attributes of one opcode
   typedef struct packed {
      logic [1:0] len;
      logic [3:0] cyc;
      logic cond;
      logic ext_move;
      logic ext_write;
      logic code_read;
      logic [2:0] program_status_word;
   } pct_dec_type;

   // Whole state of the sequencer
   typedef struct packed {
      pct_state_type state;
      logic [3:0] cnt;
      logic ready;
      logic done;
      logic [1:0] len;
      logic [3:0] cyc;
      logic [15:0] next_pc;
      logic [2:0] psw_wr;
      logic ext_move;
      logic ext_write;
      logic code_read;
      pct_space_type xspace;
      logic halted;
      logic bp_en;
      logic [15:0] bp_addr;
      logic bp_hit;
      logic halt_pend;
      logic step_once;
      logic ram_ack;
      logic dbg_ack;
   } pct_seq_type;

endpackage

// ===== pct_iram.sv
// Internal data RAM with registered read data
`timescale 1ns/1ps
`include "pct_defs.svh"

module pct_iram #(
   parameter int DEPTH = `PCT_IRAM_BYTES,
   parameter int AW = 8
) (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic req, // Access strobe
   input wire logic we, // Write when high
   input wire logic [AW-1:0] addr, // Byte address
   input wire logic [7:0] wdata, // Write byte
   output logic [7:0] rdata // Read byte, registered
);

   // Depth must fill the address range exactly
   if (DEPTH != (1 << AW)) begin : g_bad_depth
      $error("pct_iram: DEPTH must equal 2**AW");
   end

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [7:0] rdata;
   } pct_iram_type;

   pct_iram_type s_q;
   pct_iram_type s_d;

   // Write stores the byte, read loads the output register
   always_comb begin
      s_d = s_q;
      if (req && we) begin
         s_d.mem[addr] = wdata;
      end else if (req) begin
         s_d.rdata = s_q.mem[addr];
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;

endmodule // pct_iram

// ===== pct_core_timing.sv
// Instruction timing sequencer, decoder and run control of the core
`timescale 1ns/1ps
`include "pct_defs.svh"

module pct_core_timing #(
   parameter int EXPANSION_DATA_RAM_BYTES = `PCT_EXPANSION_DATA_RAM_BYTES,
   parameter bit EMIF_PRESENT = 1'b1,
   parameter int IRAM_BYTES = `PCT_IRAM_BYTES
) (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset, high
   input wire logic op_valid, // Opcode offered
   input wire logic [7:0] opcode, // First byte of instruction
   input wire logic [15:0] fetch_addr, // Address of that opcode
   input wire logic branch_taken, // Branch condition outcome
   input wire logic [15:0] xaddr, // External-data move address
   input wire logic flash_sel, // Direct external moves to flash
   input wire logic core_ram_req, // Datapath RAM strobe
   input wire logic core_ram_we, // Datapath RAM write
   input wire logic [7:0] core_ram_addr, // Datapath RAM address
   input wire logic [7:0] core_ram_wdata, // Datapath RAM write byte
   input wire logic dbg_halt_req, // Debug halt command
   input wire logic dbg_run_req, // Debug run command
   input wire logic dbg_step_req, // Debug single step command
   input wire logic dbg_bp_set, // Arm breakpoint
   input wire logic dbg_bp_clr, // Disarm breakpoint
   input wire logic [15:0] dbg_bp_addr, // Breakpoint address
   input wire logic dbg_mem_req, // Debug RAM strobe
   input wire logic dbg_mem_we, // Debug RAM write
   input wire logic [7:0] dbg_mem_addr, // Debug RAM address
   input wire logic [7:0] dbg_mem_wdata, // Debug RAM write byte
   output logic op_ready, // Opcode can be taken
   output logic instr_done, // Last cycle of instruction
   output logic [1:0] instr_len, // Bytes of current instruction
   output logic [3:0] instr_cycles, // Clocks of current instruction
   output logic [15:0] next_pc, // Sequential next address
   output logic [2:0] psw_write, // Flags written: cy, ac, ov
   output logic ext_move, // External-data move in flight
   output logic ext_write, // That move writes
   output logic code_read, // Code read in flight
   output logic [1:0] ext_space, // Target space of the move
   output logic halted, // Core stopped by debug
   output logic ram_ack, // Datapath RAM access done
   output logic dbg_mem_ack, // Debug RAM access done
   output logic [7:0] ram_rdata // RAM read byte
);

   // Sizes the logic can serve
   if (IRAM_BYTES != `PCT_IRAM_BYTES) begin : g_bad_iram
      $error("pct_core_timing: internal RAM must be 256 bytes");
   end
   if (EXPANSION_DATA_RAM_BYTES < 1 || EXPANSION_DATA_RAM_BYTES > 65536) begin : g_bad_expansion_data_ram
      $error("pct_core_timing: EXPANSION_DATA_RAM_BYTES out of range");
   end

   localparam logic [16:0] EXPANSION_DATA_RAM_LIMIT = 17'(EXPANSION_DATA_RAM_BYTES);

   pct_pkg::pct_seq_type s_q;
   pct_pkg::pct_seq_type s_d;
   pct_pkg::pct_dec_type dec;
   logic [3:0] total;
   logic finish;
   logic stop;
   logic m_req;
   logic m_we;
   logic [7:0] m_addr;
   logic [7:0] m_wdata;

   // Pack length and cycle count
   function automatic logic [5:0] lc(input logic [1:0] n, input logic [3:0] c);
      return {n, c};
   endfunction

   // Opcode table: bytes, clocks, branch and flag effects
   function automatic pct_pkg::pct_dec_type decode(input logic [7:0] op);
      pct_pkg::pct_dec_type d;
      logic [3:0] h;
      logic [3:0] l;
      d = '0;
      h = op[7:4];
      l = op[3:0];
      {d.len, d.cyc} = lc(2'h1, 4'h1);
      if (l >= 4'h8 || l == 4'h6 || l == 4'h7) begin
         // Register and indirect rows
         case (h)
            4'h7, 4'h8, 4'hA: {d.len, d.cyc} = lc(2'h2, 4'h2);
            4'hB: {d.len, d.cyc, d.cond} = {lc(2'h3, 4'h3), 1'b1};
            4'hD: {d.len, d.cyc, d.cond} = {lc(2'h2, 4'h2), l[3]};
            default: {d.len, d.cyc} = lc(2'h1, l[3] ? 4'h1 : 4'h2);
         endcase
         if (h == 4'hD && !l[3]) begin
            {d.len, d.cyc} = lc(2'h1, 4'h2); // XCHD
         end
      end else begin
         case (l)
            4'h0: begin
               case (h)
                  4'h0: {d.len, d.cyc} = lc(2'h1, 4'h1);
                  4'h1, 4'h2, 4'h3: {d.len, d.cyc, d.cond} = {lc(2'h3, 4'h3), 1'b1};
                  4'h4, 4'h5, 4'h6, 4'h7: {d.len, d.cyc, d.cond} = {lc(2'h2, 4'h2), 1'b1};
                  4'h8: {d.len, d.cyc} = lc(2'h2, 4'h4);
                  4'h9: {d.len, d.cyc} = lc(2'h3, 4'h3);
                  4'hE, 4'hF: {d.len, d.cyc, d.ext_move} = {lc(2'h1, 4'h3), 1'b1};
                  default: {d.len, d.cyc} = lc(2'h2, 4'h2);
               endcase
               d.program_status_word[`PCT_PSW_CY] = (h == 4'hA || h == 4'hB);
            end
            4'h1: {d.len, d.cyc} = lc(2'h2, 4'h4);
            4'h2: begin
               case (h)
                  4'h0, 4'h1: {d.len, d.cyc} = lc(2'h3, 4'h5);
                  4'h2, 4'h3: {d.len, d.cyc} = lc(2'h1, 4'h6);
                  4'hE, 4'hF: {d.len, d.cyc, d.ext_move} = {lc(2'h1, 4'h3), 1'b1};
                  default: {d.len, d.cyc} = lc(2'h2, 4'h2);
               endcase
               d.program_status_word[`PCT_PSW_CY] = (h == 4'h7 || h == 4'h8 || h == 4'hA);
            end
            4'h3: begin
               case (h)
                  4'h4, 4'h5, 4'h6: {d.len, d.cyc} = lc(2'h3, 4'h3);
                  4'h7: {d.len, d.cyc} = lc(2'h1, 4'h4);
                  4'h8, 4'h9: {d.len, d.cyc, d.code_read} = {lc(2'h1, 4'h3), 1'b1};
                  4'hE, 4'hF: {d.len, d.cyc, d.ext_move} = {lc(2'h1, 4'h3), 1'b1};
                  default: {d.len, d.cyc} = lc(2'h1, 4'h1);
               endcase
               d.program_status_word[`PCT_PSW_CY] = (h == 4'h1 || h == 4'h3 || h == 4'hB || h == 4'hC
                  || h == 4'hD);
            end
            4'h4: begin
               case (h)
                  4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: {d.len, d.cyc} = lc(2'h1, 4'h1);
                  4'h8: {d.len, d.cyc} = lc(2'h1, `PCT_MAX_CYCLES);
                  4'hA: {d.len, d.cyc} = lc(2'h1, 4'h4);
                  4'hB: {d.len, d.cyc, d.cond} = {lc(2'h3, 4'h3), 1'b1};
                  default: {d.len, d.cyc} = lc(2'h2, 4'h2);
               endcase
               d.program_status_word[`PCT_PSW_CY] = (h == 4'h8 || h == 4'hA || h == 4'hD);
               d.program_status_word[`PCT_PSW_OV] = (h == 4'h8 || h == 4'hA);
            end
            4'h5: begin
               case (h)
                  4'h7, 4'h8: {d.len, d.cyc} = lc(2'h3, 4'h3);
                  4'hA: {d.len, d.cyc} = lc(2'h1, 4'h1);
                  4'hB: {d.len, d.cyc, d.cond} = {lc(2'h3, 4'h3), 1'b1};
                  4'hD: {d.len, d.cyc, d.cond} = {lc(2'h3, 4'h4), 1'b1};
                  default: {d.len, d.cyc} = lc(2'h2, 4'h2);
               endcase
            end
            default: {d.len, d.cyc} = lc(2'h1, 4'h1);
         endcase
      end
      // Add, add with carry and subtract write all three flags
      if (l >= 4'h4 && (h == 4'h2 || h == 4'h3 || h == 4'h9)) begin
         d.program_status_word = 3'h7;
      end
      // Compare-and-jump writes carry
      if (l >= 4'h4 && h == 4'hB) begin
         d.program_status_word[`PCT_PSW_CY] = 1'b1;
      end
      d.ext_write = d.ext_move && h == 4'hF;
      return d;
   endfunction

   // Decode and cycle total of the offered opcode
   always_comb begin
      dec = decode(opcode);
      total = dec.cyc + ((dec.cond && branch_taken) ? `PCT_BRANCH_PENALTY : 4'h0);
   end

   // RAM port: datapath while running, debug only while halted
   always_comb begin
      if (s_q.halted) begin
         m_req = dbg_mem_req;
         m_we = dbg_mem_we;
         m_addr = dbg_mem_addr;
         m_wdata = dbg_mem_wdata;
      end else begin
         m_req = core_ram_req;
         m_we = core_ram_we;
         m_addr = core_ram_addr;
         m_wdata = core_ram_wdata;
      end
   end

   // Sequencer: counts each instruction out in system clocks
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.ram_ack = core_ram_req && !s_q.halted;
      s_d.dbg_ack = dbg_mem_req && s_q.halted;
      finish = 1'b0;
      stop = s_q.halt_pend || dbg_halt_req || s_q.bp_hit || s_q.step_once;
      // Breakpoint arm and disarm at any time
      if (dbg_bp_set) begin
         s_d.bp_en = 1'b1;
         s_d.bp_addr = dbg_bp_addr;
      end else if (dbg_bp_clr) begin
         s_d.bp_en = 1'b0;
      end
      if (dbg_halt_req && s_q.state != pct_pkg::pct_st_halt) begin
         s_d.halt_pend = 1'b1;
      end
      case (s_q.state)
         pct_pkg::pct_st_idle: begin
            if (op_valid && s_q.ready) begin
               s_d.len = dec.len;
               s_d.cyc = total;
               s_d.next_pc = fetch_addr + 16'(dec.len);
               s_d.psw_wr = dec.program_status_word;
               s_d.ext_move = dec.ext_move;
               s_d.ext_write = dec.ext_write;
               s_d.code_read = dec.code_read;
               s_d.xspace = pct_pkg::pct_sp_none;
               if (dec.code_read || (dec.ext_move && flash_sel)) begin
                  s_d.xspace = pct_pkg::pct_sp_flash;
               end else if (dec.ext_move && ({1'b0, xaddr} < EXPANSION_DATA_RAM_LIMIT || !EMIF_PRESENT)) begin
                  s_d.xspace = pct_pkg::pct_sp_expansion_data_ram;
               end else if (dec.ext_move) begin
                  s_d.xspace = pct_pkg::pct_sp_offchip;
               end
               s_d.bp_hit = s_q.bp_en && fetch_addr == s_q.bp_addr;
               s_d.cnt = total - `PCT_MIN_CYCLES;
               if (total == `PCT_MIN_CYCLES) begin
                  finish = 1'b1;
                  stop = stop || s_d.bp_hit;
               end else begin
                  s_d.state = pct_pkg::pct_st_exec;
                  s_d.ready = 1'b0;
               end
            end else if (dbg_halt_req || s_q.halt_pend) begin
               s_d.state = pct_pkg::pct_st_halt;
               s_d.ready = 1'b0;
               s_d.halted = 1'b1;
               s_d.halt_pend = 1'b0;
            end
         end
         pct_pkg::pct_st_exec: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               finish = 1'b1;
            end
         end
         pct_pkg::pct_st_halt: begin
            // Only the core stops; peripheral clocks are not touched
            if (dbg_run_req || dbg_step_req) begin
               s_d.state = pct_pkg::pct_st_idle;
               s_d.ready = 1'b1;
               s_d.halted = 1'b0;
               s_d.step_once = dbg_step_req && !dbg_run_req;
            end
         end
         default: s_d.state = pct_pkg::pct_st_idle;
      endcase
      // Last cycle of an instruction
      if (finish) begin
         s_d.done = 1'b1;
         s_d.bp_hit = 1'b0;
         s_d.step_once = 1'b0;
         s_d.halt_pend = 1'b0;
         if (stop) begin
            s_d.state = pct_pkg::pct_st_halt;
            s_d.ready = 1'b0;
            s_d.halted = 1'b1;
         end else begin
            s_d.state = pct_pkg::pct_st_idle;
            s_d.ready = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.ready <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Internal data RAM, 256 bytes
   pct_iram #(
      .DEPTH(IRAM_BYTES),
      .AW(8)
   ) u_iram (
      .core_clk(core_clk),
      .reset(reset),
      .req(m_req),
      .we(m_we),
      .addr(m_addr),
      .wdata(m_wdata),
      .rdata(ram_rdata)
   );

   // Outputs straight from the state register
   assign op_ready = s_q.ready;
   assign instr_done = s_q.done;
   assign instr_len = s_q.len;
   assign instr_cycles = s_q.cyc;
   assign next_pc = s_q.next_pc;
   assign psw_write = s_q.psw_wr;
   assign ext_move = s_q.ext_move;
   assign ext_write = s_q.ext_write;
   assign code_read = s_q.code_read;
   assign ext_space = s_q.xspace;
   assign halted = s_q.halted;
   assign ram_ack = s_q.ram_ack;
   assign dbg_mem_ack = s_q.dbg_ack;

endmodule // pct_core_timing

// ===== pct_core_timing_monitor.sv
// Port checker for the instruction timing and run control block
`timescale 1ns/1ps
module pct_core_timing_monitor (
   input wire logic core_clk, // System clock
   input wire logic reset, // Synchronous reset
   input wire logic op_valid, // Opcode offered
   input wire logic [7:0] opcode, // Opcode byte
   input wire logic [15:0] fetch_addr, // Opcode address
   input wire logic branch_taken, // Branch outcome
   input wire logic core_ram_req, // Datapath strobe
   input wire logic dbg_halt_req, // Halt command
   input wire logic dbg_run_req, // Run command
   input wire logic dbg_mem_req, // Debug strobe
   input wire logic op_ready, // Opcode can be taken
   input wire logic instr_done, // Last cycle
   input wire logic [1:0] instr_len, // Bytes
   input wire logic [3:0] instr_cycles, // Clocks
   input wire logic [15:0] next_pc, // Next address
   input wire logic halted, // Debug halt
   input wire logic ram_ack, // Datapath ack
   input wire logic dbg_mem_ack // Debug ack
);
   logic [3:0] cnt_q; // Clocks since the take
   logic take; // Opcode taken at this edge
   assign take = op_valid && op_ready;
   // Clock counter of the instruction in flight
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cnt_q <= 4'h0;
      end else if (take) begin
         cnt_q <= 4'h1;
      end else if (!op_ready) begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   done_count_a: assert property (instr_done |-> cnt_q == instr_cycles)
      else $error("done pulse not at the decoded clock count");
   cycles_bound_a: assert property (instr_done |-> instr_cycles >= 4'h1 && instr_cycles <= 4'h8)
      else $error("instruction clock count out of range");
   busy_ready_a: assert property (take |=> !op_ready || instr_done)
      else $error("opcode accepted while busy");
   next_pc_a: assert property (take |=> next_pc == $past(fetch_addr) + 16'(instr_len))
      else $error("next address is not opcode address plus length");
   branch_cost_a: assert property (take && opcode == 8'h40
      |=> instr_cycles == ($past(branch_taken) ? 4'h4 : 4'h2))
      else $error("carry branch clock count wrong");
   mul_div_a: assert property (take && (opcode == 8'hA4 || opcode == 8'h84)
      |=> instr_len == 2'h1 && instr_cycles == ($past(opcode) == 8'h84 ? 4'h8 : 4'h4))
      else $error("multiply or divide decode wrong");
   ram_ack_a: assert property (core_ram_req |=> ram_ack == !$past(halted))
      else $error("datapath ack wrong");
   dbg_ack_a: assert property (dbg_mem_req |=> dbg_mem_ack == $past(halted))
      else $error("debug memory ack wrong");
   halt_idle_a: assert property (dbg_halt_req && op_ready && !op_valid && !halted |=> halted)
      else $error("idle halt not taken");
   run_resume_a: assert property (dbg_run_req && halted |=> !halted && op_ready)
      else $error("run command did not resume");
   halt_block_a: assert property (halted && !instr_done |-> !op_ready)
      else $error("opcode offered as ready while halted");
   long_op_c: cover property (instr_done && instr_cycles == 4'h8);
   branch_c: cover property (take && opcode == 8'h40 && branch_taken);
   step_c: cover property ($rose(halted) && instr_done);
endmodule // pct_core_timing_monitor

bind pct_core_timing pct_core_timing_monitor pct_core_timing_monitor_i (
   .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .opcode(opcode),
   .fetch_addr(fetch_addr), .branch_taken(branch_taken), .core_ram_req(core_ram_req),
   .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req), .dbg_mem_req(dbg_mem_req),
   .op_ready(op_ready), .instr_done(instr_done), .instr_len(instr_len),
   .instr_cycles(instr_cycles), .next_pc(next_pc), .halted(halted), .ram_ack(ram_ack),
   .dbg_mem_ack(dbg_mem_ack));

// ===== pct_testbench.sv
// Self-checking bench of the instruction timing and run control block
`timescale 1ns/1ps
module testbench;
   logic core_clk, reset, op_valid, branch_taken, flash_sel;
   logic core_ram_req, core_ram_we, dbg_halt_req, dbg_run_req, dbg_step_req;
   logic dbg_bp_set, dbg_bp_clr, dbg_mem_req, dbg_mem_we;
   logic [7:0] opcode, core_ram_addr, core_ram_wdata, dbg_mem_addr, dbg_mem_wdata, ram_rdata;
   logic [15:0] fetch_addr, xaddr, dbg_bp_addr, next_pc;
   logic op_ready, instr_done, ext_move, ext_write, code_read, halted, ram_ack, dbg_mem_ack;
   logic [1:0] instr_len, ext_space;
   logic [3:0] instr_cycles;
   logic [2:0] psw_write;
   int n_errors = 0;
   int n_compared = 0;
   pct_core_timing pct_core_timing_i (
      .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .opcode(opcode),
      .fetch_addr(fetch_addr), .branch_taken(branch_taken), .xaddr(xaddr),
      .flash_sel(flash_sel), .core_ram_req(core_ram_req), .core_ram_we(core_ram_we),
      .core_ram_addr(core_ram_addr), .core_ram_wdata(core_ram_wdata),
      .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req), .dbg_step_req(dbg_step_req),
      .dbg_bp_set(dbg_bp_set), .dbg_bp_clr(dbg_bp_clr), .dbg_bp_addr(dbg_bp_addr),
      .dbg_mem_req(dbg_mem_req), .dbg_mem_we(dbg_mem_we), .dbg_mem_addr(dbg_mem_addr),
      .dbg_mem_wdata(dbg_mem_wdata), .op_ready(op_ready), .instr_done(instr_done),
      .instr_len(instr_len), .instr_cycles(instr_cycles), .next_pc(next_pc),
      .psw_write(psw_write), .ext_move(ext_move), .ext_write(ext_write),
      .code_read(code_read), .ext_space(ext_space), .halted(halted), .ram_ack(ram_ack),
      .dbg_mem_ack(dbg_mem_ack), .ram_rdata(ram_rdata));
   // Clock of 8 ns
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
         n_errors++;
      end
   endtask
   // Counts, verdict and end of run
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Offer one opcode, wait for its done pulse and judge the decode
   task automatic run_op(input logic [7:0] op, input logic [15:0] pc, input logic tk,
      input logic [1:0] len, input logic [3:0] cyc, input logic [2:0] program_status_word);
      int n;
      op_valid <= 1'b1;
      opcode <= op;
      fetch_addr <= pc;
      branch_taken <= tk;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!op_ready && n < 20);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!instr_done && n < 20);
      check(16'(n), 16'(cyc));
      check(16'(instr_len), 16'(len));
      check(16'(instr_cycles), 16'(cyc));
      check(next_pc, pc + 16'(len));
      check(16'(psw_write), 16'(program_status_word));
   endtask
   // One debug command pulse: halt, run, step, set, clear
   task automatic dbg_cmd(input logic [4:0] c);
      {dbg_halt_req, dbg_run_req, dbg_step_req, dbg_bp_set, dbg_bp_clr} <= c;
      @(posedge core_clk);
      {dbg_halt_req, dbg_run_req, dbg_step_req, dbg_bp_set, dbg_bp_clr} <= 5'h00;
      @(posedge core_clk);
   endtask
   // One RAM access from the datapath or the debug side
   task automatic ram_op(input logic we, input logic [7:0] a, input logic [7:0] d,
      input logic dbg, input logic ack);
      {core_ram_req, core_ram_we, core_ram_addr, core_ram_wdata} <= {!dbg, we, a, d};
      {dbg_mem_req, dbg_mem_we, dbg_mem_addr, dbg_mem_wdata} <= {dbg, we, a, d};
      @(posedge core_clk);
      core_ram_req <= 1'b0;
      dbg_mem_req <= 1'b0;
      @(posedge core_clk);
      check(16'(dbg ? dbg_mem_ack : ram_ack), 16'(ack));
      if (!we && ack) begin
         check(16'(ram_rdata), 16'(d));
      end
   endtask
   // External move or code read with its target space
   task automatic run_x(input logic [7:0] op, input logic [15:0] xa, input logic fs,
      input logic [1:0] sp, input logic [2:0] kind);
      xaddr <= xa;
      flash_sel <= fs;
      run_op(op, 16'h0200, 1'b0, 2'h1, 4'h3, 3'h0);
      check(16'(ext_space), 16'(sp));
      check(16'({ext_move, ext_write, code_read}), 16'(kind));
   endtask
   // State just after reset
   task automatic t_reset;
      check(16'({op_ready, instr_done, halted, ram_ack, instr_len}), 16'h0020);
      check(next_pc, 16'h0000);
      $display("reset test done");
   endtask
   // Both ends of internal RAM, cleared by reset
   task automatic t_ram;
      ram_op(1'b0, 8'h33, 8'h00, 1'b0, 1'b1);
      ram_op(1'b1, 8'hFF, 8'hA5, 1'b0, 1'b1);
      ram_op(1'b1, 8'h00, 8'h5A, 1'b0, 1'b1);
      ram_op(1'b0, 8'hFF, 8'hA5, 1'b0, 1'b1);
      ram_op(1'b0, 8'h00, 8'h5A, 1'b0, 1'b1);
      $display("ram test done");
   endtask
   // Clock counts of each instruction class
   task automatic t_timing;
      run_op(8'h00, 16'h0010, 1'b0, 2'h1, 4'h1, 3'h0);
      run_op(8'h28, 16'h0011, 1'b0, 2'h1, 4'h1, 3'h7);
      run_op(8'h25, 16'h0012, 1'b0, 2'h2, 4'h2, 3'h7);
      run_op(8'h26, 16'h0014, 1'b0, 2'h1, 4'h2, 3'h7);
      run_op(8'h24, 16'h0015, 1'b0, 2'h2, 4'h2, 3'h7);
      run_op(8'h53, 16'hFFFE, 1'b0, 2'h3, 4'h3, 3'h0);
      run_op(8'hA4, 16'h0020, 1'b0, 2'h1, 4'h4, 3'h5);
      run_op(8'h84, 16'h0021, 1'b0, 2'h1, 4'h8, 3'h5);
      run_op(8'h40, 16'h0030, 1'b0, 2'h2, 4'h2, 3'h0);
      run_op(8'h40, 16'h0030, 1'b1, 2'h2, 4'h4, 3'h0);
      run_op(8'h20, 16'h0040, 1'b0, 2'h3, 4'h3, 3'h0);
      run_op(8'h20, 16'h0040, 1'b1, 2'h3, 4'h5, 3'h0);
      run_op(8'hB5, 16'h0050, 1'b1, 2'h3, 4'h5, 3'h4);
      run_op(8'hD5, 16'h0060, 1'b1, 2'h3, 4'h6, 3'h0);
      run_op(8'h12, 16'h0070, 1'b0, 2'h3, 4'h5, 3'h0);
      run_op(8'h22, 16'h0080, 1'b0, 2'h1, 4'h6, 3'h0);
      $display("timing test done");
   endtask
   // Target spaces of external moves and code reads
   task automatic t_ext;
      run_x(8'hE0, 16'h0010, 1'b0, 2'h1, 3'h4);
      run_x(8'hF0, 16'h2000, 1'b0, 2'h2, 3'h6);
      run_x(8'hF0, 16'h0010, 1'b1, 2'h3, 3'h6);
      run_x(8'h93, 16'h0010, 1'b0, 2'h3, 3'h1);
      $display("external test done");
   endtask
   // Halt, refusal, debug memory, step, breakpoint and run
   task automatic t_debug;
      int n;
      dbg_cmd(5'h10);
      check(16'({halted, op_ready}), 16'h0002);
      op_valid <= 1'b1;
      repeat (4) @(posedge core_clk);
      op_valid <= 1'b0;
      check(16'(instr_done), 16'h0000);
      ram_op(1'b1, 8'h40, 8'h11, 1'b0, 1'b0);
      ram_op(1'b1, 8'h40, 8'hC3, 1'b1, 1'b1);
      ram_op(1'b0, 8'h40, 8'hC3, 1'b1, 1'b1);
      dbg_cmd(5'h04);
      run_op(8'h00, 16'h0300, 1'b0, 2'h1, 4'h1, 3'h0);
      check(16'(halted), 16'h0001);
      dbg_bp_addr <= 16'h0100;
      dbg_cmd(5'h02);
      dbg_cmd(5'h08);
      check(16'({halted, op_ready}), 16'h0001);
      run_op(8'h24, 16'h0100, 1'b0, 2'h2, 4'h2, 3'h7);
      n = 0;
      while (!halted && n < 4) begin
         @(posedge core_clk);
         n++;
      end
      check(16'(halted), 16'h0001);
      dbg_cmd(5'h01);
      dbg_cmd(5'h08);
      run_op(8'h24, 16'h0100, 1'b0, 2'h2, 4'h2, 3'h7);
      // Halt request while a multiply runs, then run and step together
      fork
         run_op(8'hA4, 16'h0400, 1'b0, 2'h1, 4'h4, 3'h5);
         begin
            repeat (2) @(posedge core_clk);
            dbg_cmd(5'h10);
         end
      join
      check(16'({halted, op_ready}), 16'h0002);
      dbg_cmd(5'h0C);
      run_op(8'h00, 16'h0500, 1'b0, 2'h1, 4'h1, 3'h0);
      repeat (4) @(posedge core_clk);
      check(16'(halted), 16'h0000);
      ram_op(1'b0, 8'h40, 8'hC3, 1'b0, 1'b1);
      $display("debug test done");
   endtask
   // Watchdog against a hang
   initial begin
      repeat (5000) @(posedge core_clk);
      n_errors++;
      give_verdict();
   end
   // Reset, then the tests in order
   initial begin
      reset <= 1'b1;
      {op_valid, branch_taken, flash_sel, core_ram_req, core_ram_we} <= 5'h00;
      {dbg_halt_req, dbg_run_req, dbg_step_req, dbg_bp_set, dbg_bp_clr} <= 5'h00;
      {dbg_mem_req, dbg_mem_we, opcode, core_ram_addr, core_ram_wdata} <= 26'h0;
      {dbg_mem_addr, dbg_mem_wdata, fetch_addr, xaddr, dbg_bp_addr} <= 64'h0;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_ram();
      t_timing();
      t_ext();
      t_debug();
      give_verdict();
   end
endmodule // testbench
